// ===== logic/atc_pkg.sv
// Purpose: Constants shared by the ambient tracking calibration block
// Assumes: 12 conversion stages, 16-bit conversion results
// Notes:   Register indices are word addresses on the register port
package atc_pkg;
    localparam int          STAGES        = 12;
    localparam int          STAGE_W       = 4;
    localparam int          DATA_W        = 16;
    localparam int          ADDR_W        = 10;
    localparam int          FAST_DEPTH    = 4;

    localparam logic [9:0]  SKIP_CTRL_ADDR = 10'h001;
    localparam logic [9:0]  COMP_CTRL_ADDR = 10'h003;
    localparam logic [15:0] SKIP_CTRL_RST  = 16'h0000;
    localparam logic [15:0] COMP_CTRL_RST  = 16'h0000;

    localparam int          FP_SKIP_LSB   = 12;
    localparam int          LP_SKIP_LSB   = 14;
    localparam int          SKIP_W        = 2;
    localparam int          RECAL_LSB     = 0;
    localparam int          RECAL_W       = 8;
    localparam int          RATE_LSB      = 8;
    localparam int          RATE_W        = 6;
    localparam int          UPD_LSB       = 14;
    localparam int          UPD_W         = 2;

    localparam int          PROX_SCALE_SH = 4;
    localparam int          UPD_SCALE_SH  = 4;
    localparam logic [4:0]  FP_SKIP_BASE  = 5'h03;
    localparam int          FP_SKIP_SH    = 2;

    localparam logic [7:0]  SENS_BASE     = 8'h10;
    localparam logic [7:0]  SENS_STEP     = 8'h03;
    localparam int          SENS_SH       = 6;
    localparam int          SKIP_CNT_W    = 5;
endpackage

// ===== logic/atc_calibration.sv
// Purpose: Per-stage ambient tracking, proximity detection and touch thresholds
// Assumes: Conversion results arrive one per cycle at most, tagged by stage
// Notes:   Slow and fast FIFO words live in the bank3 arrays below
`timescale 1ns/10ps
module atc_calibration (
    input  wire logic        sys_clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        ce_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [9:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        low_power_i,
    input  wire logic [3:0]  pos_sens_i,
    input  wire logic [3:0]  neg_sens_i,
    input  wire logic        setup_wr_i,
    input  wire logic [3:0]  setup_stage_i,
    input  wire logic [15:0] setup_upper_i,
    input  wire logic [15:0] setup_lower_i,
    input  wire logic        conv_valid_i,
    input  wire logic [3:0]  conv_stage_i,
    input  wire logic [15:0] conv_data_i,
    output logic [15:0]      reg_rdata_o,
    output logic             reg_rvalid_o,
    output logic             touch_irq_o,
    output logic [11:0]      prox_flags_o,
    output logic [11:0]      touch_flags_o
);
    logic        rst_meta_n;
    logic        rst_n;
    logic [15:0] ambient_skip_control;
    logic [15:0] ambient_comp_control_one;

    // Bank 3: slow and fast FIFO words, one set per stage
    logic [15:0] bank3_slow [atc_pkg::STAGES];
    logic [15:0] bank3_fast [atc_pkg::STAGES][atc_pkg::FAST_DEPTH];
    // Bank 2 style per-stage setup and compensation data
    logic [15:0] stage_upper_offset [atc_pkg::STAGES];
    logic [15:0] stage_lower_offset [atc_pkg::STAGES];
    logic [15:0] stage_upper_limit  [atc_pkg::STAGES];
    logic [15:0] stage_lower_limit  [atc_pkg::STAGES];
    logic [4:0]  skip_cnt [atc_pkg::STAGES];
    logic [11:0] primed;

    logic [15:0] ambient_fifo_newest;
    logic [15:0] fast_fifo_newest;
    logic [15:0] fast_fifo_fourth;
    logic [17:0] fast_sum;
    logic [15:0] fast_avg;
    logic [1:0]  fullpower_ambient_skip;
    logic [1:0]  lowpower_ambient_skip;
    logic [7:0]  hover_threshold;
    logic [5:0]  detect_rate;
    logic [1:0]  ambient_update_level;
    logic        prox_one;
    logic        prox_two;
    logic        prox_any;
    logic        slow_enable;
    logic        touched;
    logic        skip_due;
    logic        ambient_update_switch;
    logic [15:0] next_ambient;
    logic [15:0] next_upper_offset;
    logic [15:0] next_lower_offset;
    logic        stage_ok;
    logic        setup_ok;
    logic [3:0]  cur_stage;
    logic        drift_up;
    logic [15:0] drift_mag;
    logic [11:0] next_touch_flags;

    function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
        abs_diff = (a > b) ? a - b : b - a;
    endfunction

    // Percentage of an offset: 25% at setting 0 up to about 95% at 15
    function automatic logic [15:0] scale_pct(input logic [15:0] off, input logic [3:0] sens);
        logic [7:0]  mul;
        logic [23:0] prod;
        mul  = atc_pkg::SENS_BASE + atc_pkg::SENS_STEP * {4'h0, sens};
        prod = {8'h00, off} * {16'h0000, mul};
        scale_pct = prod[atc_pkg::SENS_SH +: 16];
    endfunction

    function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_add = s[16] ? 16'hFFFF : s[15:0];
    endfunction

    function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
        sat_sub = (a > b) ? a - b : 16'h0000;
    endfunction

    // Limits saturate rather than wrap, so a large offset never flips the test
    function automatic logic [15:0] upper_limit_of(input logic [15:0] amb, input logic [15:0] off,
                                                   input logic [3:0] sens);
        upper_limit_of = sat_add(amb, scale_pct(off, sens));
    endfunction

    function automatic logic [15:0] lower_limit_of(input logic [15:0] amb, input logic [15:0] off,
                                                   input logic [3:0] sens);
        lower_limit_of = sat_sub(amb, scale_pct(off, sens));
    endfunction

    // Stage codes 12 to 15 carry no data; folding keeps array reads in range
    function automatic logic [3:0] stage_index(input logic [3:0] st);
        logic [31:0] folded;
        folded      = {28'h0000000, st} % atc_pkg::STAGES;
        stage_index = folded[3:0];
    endfunction

    // A conversion or setup for a missing stage is dropped, never aliased
    function automatic logic stage_valid(input logic [3:0] st);
        stage_valid = {28'h0000000, st} < atc_pkg::STAGES;
    endfunction

    // Samples dropped between slow FIFO writes for the active mode
    function automatic logic [4:0] skip_len(input logic lp, input logic [1:0] fp_f, input logic [1:0] lp_f);
        if (lp) begin
            skip_len = {3'h0, lp_f};
        end else begin
            skip_len = atc_pkg::FP_SKIP_BASE + ({3'h0, fp_f} << atc_pkg::FP_SKIP_SH);
        end
    endfunction

    // Reset released through two flops; async assert, clocked release
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    assign fullpower_ambient_skip = ambient_skip_control[atc_pkg::FP_SKIP_LSB +: atc_pkg::SKIP_W];
    assign lowpower_ambient_skip  = ambient_skip_control[atc_pkg::LP_SKIP_LSB +: atc_pkg::SKIP_W];
    assign hover_threshold      = ambient_comp_control_one[atc_pkg::RECAL_LSB +: atc_pkg::RECAL_W];
    assign detect_rate          = ambient_comp_control_one[atc_pkg::RATE_LSB +: atc_pkg::RATE_W];
    assign ambient_update_level = ambient_comp_control_one[atc_pkg::UPD_LSB +: atc_pkg::UPD_W];

    assign stage_ok  = conv_valid_i && stage_valid(conv_stage_i);
    assign setup_ok  = setup_wr_i && stage_valid(setup_stage_i);
    assign cur_stage = stage_index(conv_stage_i);

    // This block indexes only the converting stage's words
    always_comb begin
        ambient_fifo_newest = bank3_slow[cur_stage];
        fast_fifo_newest    = bank3_fast[cur_stage][0];
        fast_fifo_fourth    = bank3_fast[cur_stage][3];
        fast_sum = {2'b00, bank3_fast[cur_stage][0]}
                 + {2'b00, bank3_fast[cur_stage][1]}
                 + {2'b00, bank3_fast[cur_stage][2]}
                 + {2'b00, bank3_fast[cur_stage][3]};
        fast_avg = fast_sum[17:2];
    end

    assign prox_one = abs_diff(fast_fifo_newest, fast_fifo_fourth)
                      > ({10'h000, detect_rate} << atc_pkg::PROX_SCALE_SH);
    assign prox_two = abs_diff(fast_avg, ambient_fifo_newest)
                      > ({8'h00, hover_threshold} << atc_pkg::PROX_SCALE_SH);
    assign prox_any = prox_one || prox_two;

    assign slow_enable = !prox_any && (abs_diff(ambient_fifo_newest, conv_data_i)
                         > ({14'h0000, ambient_update_level} << atc_pkg::UPD_SCALE_SH));

    // Touch test against the stage's current limits
    always_comb begin
        touched = (conv_data_i > stage_upper_limit[cur_stage])
               || (conv_data_i < stage_lower_limit[cur_stage]);
    end

    // Flag vector as it will stand after this edge; the interrupt follows it
    always_comb begin
        next_touch_flags = touch_flags_o;
        if (stage_ok) begin
            next_touch_flags[cur_stage] = touched;
        end
    end

    assign skip_due = skip_cnt[cur_stage]
                      >= skip_len(low_power_i, fullpower_ambient_skip, lowpower_ambient_skip);

    // Compensation only while untouched; first sample past the skip count seeds the ambient
    assign ambient_update_switch = stage_ok && !touched && skip_due
                                   && (slow_enable || !primed[cur_stage]);

    // Drift is taken against the newest slow word, before it is replaced
    assign drift_up  = conv_data_i > ambient_fifo_newest;
    assign drift_mag = abs_diff(conv_data_i, ambient_fifo_newest);

    // Drift moves both offsets the opposite way, keeping the clamp headroom
    always_comb begin
        next_ambient      = conv_data_i;
        next_upper_offset = stage_upper_offset[cur_stage];
        next_lower_offset = stage_lower_offset[cur_stage];
        if (primed[cur_stage]) begin
            if (drift_up) begin
                next_upper_offset = sat_sub(next_upper_offset, drift_mag);
                next_lower_offset = sat_add(next_lower_offset, drift_mag);
            end else begin
                next_upper_offset = sat_add(next_upper_offset, drift_mag);
                next_lower_offset = sat_sub(next_lower_offset, drift_mag);
            end
        end
    end

    // Register port
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ambient_skip_control     <= atc_pkg::SKIP_CTRL_RST;
            ambient_comp_control_one <= atc_pkg::COMP_CTRL_RST;
        end else if (ce_i && reg_wr_i) begin
            if (reg_addr_i == atc_pkg::SKIP_CTRL_ADDR) begin
                ambient_skip_control <= reg_wdata_i;
            end else if (reg_addr_i == atc_pkg::COMP_CTRL_ADDR) begin
                ambient_comp_control_one <= reg_wdata_i;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o  <= 16'h0000;
            reg_rvalid_o <= 1'b0;
        end else if (ce_i) begin
            reg_rvalid_o <= reg_rd_i;
            if (!reg_rd_i) begin
                reg_rdata_o <= 16'h0000;
            end else if (reg_addr_i == atc_pkg::SKIP_CTRL_ADDR) begin
                reg_rdata_o <= ambient_skip_control;
            end else if (reg_addr_i == atc_pkg::COMP_CTRL_ADDR) begin
                reg_rdata_o <= ambient_comp_control_one;
            end else begin
                reg_rdata_o <= 16'h0000;
            end
        end
    end

    // Fast FIFO shifts on every conversion of its stage
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            for (int s = 0; s < atc_pkg::STAGES; s++) begin
                for (int w = 0; w < atc_pkg::FAST_DEPTH; w++) begin
                    bank3_fast[s][w] <= 16'h0000;
                end
            end
        end else if (ce_i && stage_ok) begin
            bank3_fast[conv_stage_i][0] <= conv_data_i;
            for (int w = 1; w < atc_pkg::FAST_DEPTH; w++) begin
                bank3_fast[conv_stage_i][w] <= bank3_fast[conv_stage_i][w-1];
            end
        end
    end

    // Skip counter restarts whenever the slow FIFO is considered
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            for (int s = 0; s < atc_pkg::STAGES; s++) begin
                skip_cnt[s] <= 5'h00;
            end
        end else if (ce_i && stage_ok) begin
            if (skip_due) begin
                skip_cnt[conv_stage_i] <= 5'h00;
            end else begin
                skip_cnt[conv_stage_i] <= skip_cnt[conv_stage_i] + 5'h01;
            end
        end
    end

    // Slow FIFO, offsets and limits; setup write wins for its own stage
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            primed <= 12'h000;
            for (int s = 0; s < atc_pkg::STAGES; s++) begin
                bank3_slow[s]         <= 16'h0000;
                stage_upper_offset[s] <= 16'h0000;
                stage_lower_offset[s] <= 16'h0000;
                stage_upper_limit[s]  <= 16'hFFFF;
                stage_lower_limit[s]  <= 16'h0000;
            end
        end else if (ce_i) begin
            if (ambient_update_switch && !(setup_ok && setup_stage_i == conv_stage_i)) begin
                primed[conv_stage_i]             <= 1'b1;
                bank3_slow[conv_stage_i]         <= next_ambient;
                stage_upper_offset[conv_stage_i] <= next_upper_offset;
                stage_lower_offset[conv_stage_i] <= next_lower_offset;
                stage_upper_limit[conv_stage_i]  <= upper_limit_of(next_ambient, next_upper_offset,
                    pos_sens_i);
                stage_lower_limit[conv_stage_i]  <= lower_limit_of(next_ambient, next_lower_offset,
                    neg_sens_i);
            end
            if (setup_ok) begin
                stage_upper_offset[setup_stage_i] <= setup_upper_i;
                stage_lower_offset[setup_stage_i] <= setup_lower_i;
                stage_upper_limit[setup_stage_i]  <= upper_limit_of(bank3_slow[setup_stage_i], setup_upper_i,
                    pos_sens_i);
                stage_lower_limit[setup_stage_i]  <= lower_limit_of(bank3_slow[setup_stage_i], setup_lower_i,
                    neg_sens_i);
            end
        end
    end

    // Per-stage flags; touch interrupt is a level while any stage is touched
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            prox_flags_o  <= 12'h000;
            touch_flags_o <= 12'h000;
            touch_irq_o   <= 1'b0;
        end else if (ce_i) begin
            if (stage_ok) begin
                prox_flags_o[conv_stage_i]  <= prox_any;
                touch_flags_o[conv_stage_i] <= touched;
            end
            touch_irq_o <= |next_touch_flags;
        end
    end
endmodule

// ===== testbench/atc_checker.sv
// Purpose: Port-level assertions for the ambient tracking calibration block
// Assumes: One clock domain, reset by arst_n_i
// Notes:   Bound onto atc_calibration from the bench top
`timescale 1ns/10ps
module atc_checker (
    input wire logic        sys_clk_i,
    input wire logic        arst_n_i,
    input wire logic        ce_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [9:0]  reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic        conv_valid_i,
    input wire logic [3:0]  conv_stage_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic        reg_rvalid_o,
    input wire logic        touch_irq_o,
    input wire logic [11:0] prox_flags_o,
    input wire logic [11:0] touch_flags_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    logic take_rd;
    logic take_cv;
    assign take_rd = ce_i && reg_rd_i;
    assign take_cv = ce_i && conv_valid_i && (conv_stage_i < 4'hC);
    a_read_answered: assert property (take_rd |=> reg_rvalid_o) else $error("read not answered");
    a_no_stray_valid: assert property (ce_i && !reg_rd_i |=> !reg_rvalid_o) else $error("stray read valid");
    a_idle_rdata_zero: assert property (!reg_rvalid_o |-> reg_rdata_o == 16'h0000) else $error("idle data");
    a_unmapped_zero: assert property (take_rd && reg_addr_i != 10'h001 && reg_addr_i != 10'h003
        |=> reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
    a_comp_readback: assert property ((ce_i && reg_wr_i && reg_addr_i == 10'h003) ##1 (take_rd && !reg_wr_i
        && reg_addr_i == 10'h003) |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("readback");
    a_irq_any_touch: assert property (touch_irq_o == (|touch_flags_o)) else $error("irq not any touch");
    a_flags_hold: assert property (!take_cv |=> $stable(touch_flags_o) && $stable(prox_flags_o))
        else $error("flags moved without conversion");
    a_stage_isolated: assert property (take_cv |=> (((touch_flags_o ^ $past(touch_flags_o))
        | (prox_flags_o ^ $past(prox_flags_o))) & ~(12'h001 << $past(conv_stage_i))) == 12'h000)
        else $error("other stage flag moved");
    c_touch: cover property ($rose(touch_irq_o));
    c_prox: cover property ($rose(|prox_flags_o));
    c_read: cover property (take_rd ##1 reg_rvalid_o);
endmodule

// ===== testbench/atc_conv_model.sv
// Purpose: Conversion sequencer model feeding per-stage results
// Assumes: One result per call, optional idle gap before it
// Notes:   Released fields are scrambled so stale values are never trusted
`timescale 1ns/10ps
module atc_conv_model (
    input  wire logic   sys_clk_i,
    output logic        conv_valid_o,
    output logic [3:0]  conv_stage_o,
    output logic [15:0] conv_data_o
);
    initial begin
        conv_valid_o = 1'b0;
        conv_stage_o = 4'hF;
        conv_data_o  = 16'h0000;
    end
    task automatic send(input logic [3:0] st, input logic [15:0] d, input int gap);
        repeat (gap) @(posedge sys_clk_i);
        @(posedge sys_clk_i);
        conv_valid_o <= 1'b1;
        conv_stage_o <= st;
        conv_data_o  <= d;
        @(posedge sys_clk_i);
        conv_valid_o <= 1'b0;
        conv_stage_o <= ~st;
        conv_data_o  <= ~d;
        @(negedge sys_clk_i);
    endtask
endmodule

// ===== testbench/tb.sv
// Purpose: Self-checking bench for the ambient tracking calibration block
// Assumes: Skip fields of zero; stage 2 runs low power, stage 5 full power
// Notes:   Stage 2 ambient stays fixed; stage 5 takes one drift step
`timescale 1ns/10ps
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin miscompares++; $display("MISMATCH %0t %s", $time, m); end end
module tb;
    localparam logic [15:0] AMB = 16'h0800;
    logic        sys_clk, arst_n, ce, reg_wr, reg_rd, setup_wr, conv_valid, reg_rvalid, touch_irq, low_power;
    logic [9:0]  reg_addr;
    logic [15:0] reg_wdata, setup_upper, setup_lower, conv_data, reg_rdata;
    logic [3:0]  setup_stage, conv_stage;
    logic [11:0] prox_flags, touch_flags;
    int          miscompares, compares;
    atc_calibration u_atc_calibration (.sys_clk_i(sys_clk), .arst_n_i(arst_n), .ce_i(ce), .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .low_power_i(low_power),
        .pos_sens_i(4'h0), .neg_sens_i(4'hF), .setup_wr_i(setup_wr), .setup_stage_i(setup_stage),
        .setup_upper_i(setup_upper), .setup_lower_i(setup_lower), .conv_valid_i(conv_valid),
        .conv_stage_i(conv_stage), .conv_data_i(conv_data), .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid),
        .touch_irq_o(touch_irq), .prox_flags_o(prox_flags), .touch_flags_o(touch_flags));
    atc_conv_model u_atc_conv_model (.sys_clk_i(sys_clk), .conv_valid_o(conv_valid), .conv_stage_o(conv_stage),
        .conv_data_o(conv_data));
    task automatic summarize();
        if (miscompares == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Write (optional) then read at the very next edge
    task automatic wr_rd(input logic [9:0] a, input logic [15:0] d, input logic [15:0] e, input logic w,
                         input logic c);
        @(posedge sys_clk);
        reg_wr <= w;
        ce <= c;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        ce <= 1'b1;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        `CHK(reg_rvalid, 1'b1, "read valid")
        `CHK(reg_rdata, e, "read data")
    endtask
    task automatic stage_setup(input logic [3:0] st, input logic [15:0] up, input logic [15:0] lo);
        @(posedge sys_clk);
        setup_wr <= 1'b1;
        setup_stage <= st;
        setup_upper <= up;
        setup_lower <= lo;
        @(posedge sys_clk);
        setup_wr <= 1'b0;
    endtask
    task automatic conv(input logic [3:0] st, input logic [15:0] d, input logic [11:0] et, input logic ep,
                        input int gap);
        u_atc_conv_model.send(st, d, gap);
        `CHK(touch_flags, et, "touch flags")
        `CHK(touch_irq, |et, "touch irq")
        `CHK(prox_flags[st % 4'hC], ep, "proximity flag")
    endtask
    task automatic t_regs();
        wr_rd(10'h001, 16'h0000, 16'h0000, 1'b0, 1'b1);
        wr_rd(10'h003, 16'h0000, 16'h0000, 1'b0, 1'b1);
        wr_rd(10'h001, 16'hB123, 16'hB123, 1'b1, 1'b1);
        wr_rd(10'h001, 16'h0000, 16'hB123, 1'b1, 1'b0);
        wr_rd(10'h002, 16'hFFFF, 16'h0000, 1'b1, 1'b1);
        wr_rd(10'h003, 16'h3FFF, 16'h3FFF, 1'b1, 1'b1);
        wr_rd(10'h001, 16'h0000, 16'h0000, 1'b1, 1'b1);
    endtask
    task automatic t_track();
        repeat (4) u_atc_conv_model.send(4'h2, AMB, 0);
        conv(4'h2, AMB, 12'h000, 1'b0, 2);
        stage_setup(4'h2, 16'h0400, 16'h0400);
        conv(4'h2, 16'h0901, 12'h004, 1'b0, 0);
        conv(4'h2, 16'h042F, 12'h004, 1'b0, 0);
        conv(4'hC, 16'hFFFF, 12'h004, 1'b0, 0);
        repeat (4) conv(4'h2, AMB, 12'h000, 1'b0, 0);
    endtask
    task automatic t_prox();
        wr_rd(10'h003, 16'hC1FF, 16'hC1FF, 1'b1, 1'b1);
        conv(4'h2, 16'h0810, 12'h000, 1'b0, 0);
        conv(4'h2, 16'h0811, 12'h000, 1'b0, 0);
        conv(4'h2, 16'h0811, 12'h000, 1'b1, 0);
        wr_rd(10'h003, 16'hFF00, 16'hFF00, 1'b1, 1'b1);
        conv(4'h2, AMB, 12'h000, 1'b1, 0);
    endtask
    // Full power, skip field 00: three samples dropped, the fourth seeds
    task automatic t_drift();
        wr_rd(10'h003, 16'h3F80, 16'h3F80, 1'b1, 1'b1);
        @(posedge sys_clk);
        low_power <= 1'b0;
        repeat (3) u_atc_conv_model.send(4'h5, 16'h1000, 0);
        conv(4'h5, 16'h1001, 12'h000, 1'b1, 0);
        conv(4'h5, 16'h1002, 12'h020, 1'b0, 0);
        stage_setup(4'h5, 16'h0400, 16'h0400);
        repeat (2) conv(4'h5, 16'h1001, 12'h000, 1'b0, 0);
        conv(4'h5, 16'h1011, 12'h000, 1'b0, 0);
        conv(4'h5, 16'h1102, 12'h000, 1'b0, 0);
        conv(4'h5, 16'h110E, 12'h020, 1'b0, 0);
    endtask
    task automatic t_reset();
        @(posedge sys_clk);
        arst_n <= 1'b0;
        @(negedge sys_clk);
        `CHK(prox_flags, 12'h000, "flags after reset")
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        wr_rd(10'h003, 16'h0000, 16'h0000, 1'b0, 1'b1);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (4000) @(posedge sys_clk);
        miscompares++;
        $display("MISMATCH %0t run limit reached", $time);
        summarize();
    end
    initial begin
        {arst_n, ce, reg_wr, reg_rd, setup_wr, low_power} = 6'b010001;
        reg_addr = 10'h000;
        reg_wdata = 16'h0000;
        setup_stage = 4'h0;
        setup_upper = 16'h0000;
        setup_lower = 16'h0000;
        miscompares = 0;
        compares = 0;
        repeat (20) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_regs();
        t_track();
        t_prox();
        t_drift();
        t_reset();
        summarize();
    end
endmodule
bind atc_calibration atc_checker u_atc_checker (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .conv_valid_i(conv_valid_i), .conv_stage_i(conv_stage_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .touch_irq_o(touch_irq_o), .prox_flags_o(prox_flags_o),
    .touch_flags_o(touch_flags_o));
